//--- shared/iox_params.svh
// Behaviour
// - four 8-bit registers, one bit per pin
// - all pins are inputs after power-up
// - direction bit selects input or output per pin
// - invert bit flips returned input level
// - every register reads back its contents
// - reset pin equals power-on reset
// - registers held at default while reset low
// - input pin has both drivers off
// - output pin drives high or low side per bit
// - input change asserts alert within valid delay
// - alert clears on return or input read
// - read clears alert at acknowledge rising edge
// - change during acknowledge pulse may be lost; code loses changes from read-byte load to acknowledge rise
// - later changes raise alert afresh
// - traffic for other targets leaves alert alone
// - outputs never alert; output-to-input may alert
// - alert output is open-drain active low
// - one pin chooses one of two addresses
// - pointer 00 selects input, repeat reads allowed
// - read without own address gets not-acknowledge
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH

`define IOX_WIDTH       8
`define IOX_PTR_INPUT   2'h0
`define IOX_PTR_OUTPUT  2'h1
`define IOX_PTR_INVERT  2'h2
`define IOX_PTR_DIR     2'h3
`define IOX_RST_DIR     8'hff
`define IOX_RST_OUTPUT  8'hff
`define IOX_RST_INVERT  8'h00
`define IOX_RST_PTR     2'h0
// the start condition's own scl fall wraps this to zero
`define IOX_START_CNT   4'hf
`define IOX_ADDR_BASE   6'h10
`define IOX_ACK_BIT     4'h8
`define IOX_LAST_BIT    4'h7
`define IOX_CLK_NS      40
`define IOX_T_IV_NS     4000
`define IOX_T_IV_CYC    (`IOX_T_IV_NS / `IOX_CLK_NS)

`endif

//--- shared/iox_pkg.sv
package iox_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_cmd,
		st_wr,
		st_rd
	} iox_state_e;

	typedef struct packed {
		logic [7:0] high_side_driver;
		logic [7:0] low_side_driver;
	} iox_drv_s;

endpackage : iox_pkg

//--- hdl/iox_port_core.sv
`timescale 1ns/1ns
`include "iox_params.svh"

module iox_port_core #(
	parameter int W = `IOX_WIDTH
) (
	input  wire logic            mclk,
	input  wire logic            reset,
	input  wire logic            scl,
	input  wire logic            sda_in,
	output logic                 sda_out,
	output logic                 sda_oe,
	input  wire logic            reset_n_pin,
	input  wire logic            bus_addr_sel,
	input  wire logic [W-1:0]    port_pins_in,
	output logic      [W-1:0]    port_pins_out,
	output logic      [W-1:0]    port_pins_oe,
	output iox_pkg::iox_drv_s    port_drv,
	output logic                 alert_n,
	output logic                 alert_n_oe
);

	// link domain: data bit captured on the scl rising edge itself
	logic              lbit_r;

	// mclk domain
	logic              rstn_s1_r;
	logic              rstn_s2_r;
	logic              asel_s1_r;
	logic              asel_s2_r;
	logic              scl_s1_r;
	logic              scl_s2_r;
	logic              scl_s3_r;
	logic              sda_s1_r;
	logic              sda_s2_r;
	logic              sda_s3_r;
	logic              lbit_m1_r;
	logic              lbit_m2_r;
	logic [W-1:0]      pin_s1_r;
	logic [W-1:0]      pin_s2_r;

	logic [W-1:0]      dir_r;
	logic [W-1:0]      out_r;
	logic [W-1:0]      inv_r;
	logic [W-1:0]      cap_r;
	logic [1:0]        ptr_r;
	logic              alert_r;

	iox_pkg::iox_state_e state_r;
	iox_pkg::iox_state_e go_st_r;
	logic [3:0]        bit_cnt_r;
	logic [7:0]        rx_r;
	logic [7:0]        tx_r;
	logic              mack_r;
	logic              sda_oe_r;

	wire               rst_all;
	wire               rise_ev;
	wire               scl_fall;
	wire               start_ev;
	wire               stop_ev;
	wire               active;
	wire               ack_slot;
	wire               byte_done;
	wire               ack_fall;
	wire [6:0]         own_addr;
	wire               addr_hit;
	wire               wr_en;
	wire               wr_out;
	wire               wr_inv;
	wire               wr_dir;
	wire [W-1:0]       input_level;
	wire [W-1:0]       rd_data;
	wire               load_rd;
	wire               rd_ack_ev;
	wire [W-1:0]       mism;

	// no reset: scl is idle outside frames, so a reset would never reach it;
	// the bit is only read after a rise has refreshed it
	always_ff @(posedge scl) begin
		lbit_r <= sda_in;
	end

	// every pin-side input passes two flops first
	always_ff @(posedge mclk) begin
		if (reset) begin
			rstn_s1_r <= 1'b1;
			rstn_s2_r <= 1'b1;
		end else begin
			rstn_s1_r <= reset_n_pin;
			rstn_s2_r <= rstn_s1_r;
		end
	end

	assign rst_all = reset | ~rstn_s2_r;

	always_ff @(posedge mclk) begin
		asel_s1_r <= bus_addr_sel;
		asel_s2_r <= asel_s1_r;
		scl_s1_r  <= scl;
		scl_s2_r  <= scl_s1_r;
		scl_s3_r  <= scl_s2_r;
		sda_s1_r  <= sda_in;
		sda_s2_r  <= sda_s1_r;
		sda_s3_r  <= sda_s2_r;
		lbit_m1_r <= lbit_r;
		lbit_m2_r <= lbit_m1_r;
		pin_s1_r  <= port_pins_in;
		pin_s2_r  <= pin_s1_r;
	end

	// bus event decode
	// same two-flop latency as the captured bit, so both line up
	assign rise_ev   = scl_s2_r & ~scl_s3_r;
	assign scl_fall  = scl_s3_r & ~scl_s2_r;
	assign start_ev  = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign stop_ev   = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
	assign active    = (state_r != iox_pkg::st_idle);
	assign ack_slot  = (bit_cnt_r == `IOX_ACK_BIT);
	assign byte_done = active & scl_fall & (bit_cnt_r == `IOX_LAST_BIT);
	assign ack_fall  = active & scl_fall & ack_slot;
	assign own_addr  = {`IOX_ADDR_BASE, asel_s2_r};
	assign addr_hit  = (rx_r[7:1] == own_addr);

	// register writes land when the data byte completes
	assign wr_en  = byte_done & (state_r == iox_pkg::st_wr);
	assign wr_out = wr_en & (ptr_r == `IOX_PTR_OUTPUT);
	assign wr_inv = wr_en & (ptr_r == `IOX_PTR_INVERT);
	assign wr_dir = wr_en & (ptr_r == `IOX_PTR_DIR);

	assign input_level = pin_s2_r ^ inv_r;
	assign rd_data = (ptr_r == `IOX_PTR_INPUT)  ? input_level :
	                 (ptr_r == `IOX_PTR_OUTPUT) ? out_r :
	                 (ptr_r == `IOX_PTR_INVERT) ? inv_r : dir_r;

	assign load_rd   = ack_fall & (go_st_r == iox_pkg::st_rd) &
	                   ((state_r == iox_pkg::st_addr) | mack_r);
	// clear rides on the acknowledge rising edge, so a pin change after the read
	// byte was loaded and before that edge is absorbed into the fresh reference
	assign rd_ack_ev = rise_ev & ack_slot & (state_r == iox_pkg::st_rd) &
	                   (ptr_r == `IOX_PTR_INPUT);

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			dir_r <= `IOX_RST_DIR;
			out_r <= `IOX_RST_OUTPUT;
			inv_r <= `IOX_RST_INVERT;
		end else begin
			if (wr_dir) begin
				dir_r <= rx_r;
			end
			if (wr_out) begin
				out_r <= rx_r;
			end
			if (wr_inv) begin
				inv_r <= rx_r;
			end
		end
	end

	// reference for change detection; held to pins during reset
	always_ff @(posedge mclk) begin
		if (rst_all | rd_ack_ev) begin
			cap_r <= pin_s2_r;
		end
	end

	// output pins never compare, so they never alert
	assign mism = (pin_s2_r ^ cap_r) & dir_r;

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= |mism;
		end
	end

	assign alert_n    = 1'b0;
	assign alert_n_oe = alert_r;

	// drivers: input bits float, output bits follow the output register
	assign port_pins_oe  = ~dir_r;
	assign port_pins_out = out_r;
	assign port_drv.high_side_driver = ~dir_r & out_r;
	assign port_drv.low_side_driver  = ~dir_r & ~out_r;

	// serial target
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			state_r   <= iox_pkg::st_idle;
			go_st_r   <= iox_pkg::st_idle;
			bit_cnt_r <= 4'h0;
			rx_r      <= 8'h00;
			tx_r      <= 8'h00;
			mack_r    <= 1'b0;
			sda_oe_r  <= 1'b0;
			ptr_r     <= `IOX_RST_PTR;
		end else if (start_ev) begin
			state_r   <= iox_pkg::st_addr;
			bit_cnt_r <= `IOX_START_CNT;
			sda_oe_r  <= 1'b0;
		end else if (stop_ev) begin
			state_r  <= iox_pkg::st_idle;
			sda_oe_r <= 1'b0;
		end else if (active & rise_ev) begin
			if (ack_slot) begin
				mack_r <= ~lbit_m2_r;
			end else begin
				rx_r <= {rx_r[6:0], lbit_m2_r};
			end
		end else if (byte_done) begin
			bit_cnt_r <= `IOX_ACK_BIT;
			case (state_r)
				iox_pkg::st_addr: begin
					// foreign address: stay silent, traffic is ignored
					sda_oe_r <= addr_hit;
					if (!addr_hit) begin
						go_st_r <= iox_pkg::st_idle;
					end else if (rx_r[0]) begin
						go_st_r <= iox_pkg::st_rd;
					end else begin
						go_st_r <= iox_pkg::st_cmd;
					end
				end
				iox_pkg::st_cmd: begin
					ptr_r    <= rx_r[1:0];
					sda_oe_r <= 1'b1;
					go_st_r  <= iox_pkg::st_wr;
				end
				iox_pkg::st_wr: begin
					sda_oe_r <= 1'b1;
					go_st_r  <= iox_pkg::st_wr;
				end
				iox_pkg::st_rd: begin
					sda_oe_r <= 1'b0;
					go_st_r  <= iox_pkg::st_rd;
				end
				default: begin
					sda_oe_r <= 1'b0;
					go_st_r  <= iox_pkg::st_idle;
				end
			endcase
		end else if (ack_fall) begin
			bit_cnt_r <= 4'h0;
			if (load_rd) begin
				state_r  <= iox_pkg::st_rd;
				sda_oe_r <= ~rd_data[7];
				tx_r     <= {rd_data[6:0], 1'b0};
			end else if (go_st_r == iox_pkg::st_rd) begin
				state_r  <= iox_pkg::st_idle;
				sda_oe_r <= 1'b0;
			end else begin
				state_r  <= go_st_r;
				sda_oe_r <= 1'b0;
			end
		end else if (active & scl_fall) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			if (state_r == iox_pkg::st_rd) begin
				sda_oe_r <= ~tx_r[7];
				tx_r     <= {tx_r[6:0], 1'b0};
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_r;

	// checks
	localparam int IV_MAX = `IOX_T_IV_CYC;

	sequence s_hit_byte;
		byte_done && state_r == iox_pkg::st_addr && addr_hit;
	endsequence

	sequence s_miss_byte;
		byte_done && state_r == iox_pkg::st_addr && !addr_hit;
	endsequence

	a_reset_defaults: assert property (@(posedge mclk)
		rst_all |=> dir_r == `IOX_RST_DIR && inv_r == `IOX_RST_INVERT && out_r == `IOX_RST_OUTPUT)
		else $error("registers not at default after reset");

	a_reset_inputs: assert property (@(posedge mclk)
		rst_all |=> port_pins_oe == '0 && !alert_n_oe)
		else $error("pin driven or alert after reset");

	a_input_hiz: assert property (@(posedge mclk) disable iff (rst_all)
		((port_drv.high_side_driver | port_drv.low_side_driver) & dir_r) == '0)
		else $error("input pin has a driver on");

	a_output_drive: assert property (@(posedge mclk) disable iff (rst_all)
		(port_drv.high_side_driver ^ port_drv.low_side_driver) == ~dir_r
		&& (port_drv.high_side_driver & ~dir_r) == (out_r & ~dir_r))
		else $error("output driver does not follow output register");

	a_dir_write: assert property (@(posedge mclk) disable iff (rst_all)
		wr_dir |=> dir_r == $past(rx_r) && port_pins_oe == ~$past(rx_r))
		else $error("direction write not applied");

	a_alert_valid: assert property (@(posedge mclk) disable iff (rst_all)
		(|mism && !rd_ack_ev) [*2] |-> ##[0:IV_MAX] alert_n_oe)
		else $error("alert late after input change");

	a_out_quiet: assert property (@(posedge mclk) disable iff (rst_all)
		(((pin_s2_r ^ cap_r) & dir_r) == '0) |=> !alert_n_oe)
		else $error("alert without input-mode mismatch");

	a_read_clear: assert property (@(posedge mclk) disable iff (rst_all)
		rd_ack_ev |=> cap_r == $past(pin_s2_r) ##1 alert_n_oe == $past(|mism))
		else $error("input read did not refresh reference");

	a_other_target: assert property (@(posedge mclk) disable iff (rst_all)
		s_miss_byte |=> (!sda_oe) [*2])
		else $error("foreign address answered");

	a_own_ack: assert property (@(posedge mclk) disable iff (rst_all || start_ev || stop_ev)
		s_hit_byte |=> sda_oe)
		else $error("own address not acknowledged");

	a_invert_load: assert property (@(posedge mclk) disable iff (rst_all)
		(load_rd && ptr_r == `IOX_PTR_INPUT) |-> sda_oe_r == sda_oe_r ##1 !sda_oe == $past(input_level[7]))
		else $error("first read bit not the inverted pin level");

	a_idle_ref: assert property (@(posedge mclk) disable iff (rst_all)
		(state_r == iox_pkg::st_idle && !rd_ack_ev) |=> $stable(cap_r))
		else $error("reference moved without an input read");

endmodule : iox_port_core

//--- tb/iox_i2c_master.sv
`timescale 1ns/1ns
module iox_i2c_master (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      pull
);
	// quarter bit in mclk; the bench may raise it to act as a slow master
	int q = 8;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask : hold
	// also serves as repeated start when scl is low
	task automatic start();
		pull <= 1'b0;
		hold(q);
		scl <= 1'b1;
		hold(q);
		pull <= 1'b1;
		hold(q);
		scl <= 1'b0;
		hold(q);
	endtask : start
	// scl and sda left idle high; no clock outside frames
	task automatic stop();
		pull <= 1'b1;
		hold(q);
		scl <= 1'b1;
		hold(q);
		pull <= 1'b0;
		hold(q);
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		pull <= ~b;
		hold(q);
		scl <= 1'b1;
		hold(q);
		r = sda;
		hold(q);
		scl <= 1'b0;
		hold(q);
	endtask : bitx
	// nak high releases sda in the ninth slot
	task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(nak, ack);
	endtask : xfer
endmodule : iox_i2c_master

//--- tb/iox_port_core_tb_top.sv
`timescale 1ns/1ns
`include "iox_params.svh"
module iox_port_core_tb_top;
	logic              mclk;
	logic              reset;
	logic              reset_n_pin;
	logic              bus_addr_sel;
	logic              scl;
	logic              pull;
	logic [7:0]        pins;
	wire               sda;
	wire  logic        sda_oe;
	wire  logic        alert_n_oe;
	wire  logic [7:0]  pins_out;
	wire  logic [7:0]  pins_oe;
	iox_pkg::iox_drv_s drv;
	int                fail_count;
	int                samples_checked;
	logic [7:0]        exp_q[$];
	logic [7:0]        got_q[$];
	string             nm_q[$];
	logic [7:0]        r;
	logic [7:0]        v;
	logic [7:0]        o;
	logic [7:0]        inv;
	logic [7:0]        dir;
	logic              a;
	assign sda = ~(sda_oe | pull);
	iox_port_core uut (.mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.reset_n_pin(reset_n_pin), .bus_addr_sel(bus_addr_sel), .port_pins_in(pins), .port_pins_out(pins_out),
		.port_pins_oe(pins_oe), .port_drv(drv), .alert_n(), .alert_n_oe(alert_n_oe));
	iox_i2c_master m (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		nm_q.push_back(n);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask : chk
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	initial forever begin
		wait (got_q.size() > 0);
		cmp(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
	end
	task automatic go(input logic rw, input logic [5:0] base);
		m.start();
		m.xfer({base, bus_addr_sel, rw}, 1'b1, r, a);
	endtask : go
	task automatic cmd(input logic [1:0] p);
		go(1'b0, `IOX_ADDR_BASE);
		chk("addr ack", 8'h00, {7'h00, a});
		m.xfer({6'h00, p}, 1'b1, r, a);
	endtask : cmd
	task automatic wr(input logic [1:0] p, input logic [7:0] d);
		cmd(p);
		m.xfer(d, 1'b1, r, a);
		m.stop();
	endtask : wr
	task automatic rd(input logic [1:0] p, input logic np);
		if (np) begin
			cmd(p);
			m.stop();
		end
		go(1'b1, `IOX_ADDR_BASE);
		m.xfer(8'hff, 1'b1, v, a);
		m.stop();
	endtask : rd
	task automatic alert(input logic e);
		for (int i = 0; i < `IOX_T_IV_CYC && alert_n_oe !== e; i++) begin
			@(posedge mclk);
		end
		chk("alert", {7'h00, e}, {7'h00, alert_n_oe});
	endtask : alert
	task automatic print_verdict();
		#1;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		print_verdict();
	end
	initial begin
		reset = 1'b1;
		reset_n_pin = 1'b1;
		bus_addr_sel = 1'b0;
		pins = 8'h00;
		void'($urandom(14));
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		chk("oe", 8'h00, pins_oe);
		chk("drivers", 8'h00, drv.high_side_driver | drv.low_side_driver);
		rd(2'h1, 1'b1);
		chk("output", `IOX_RST_OUTPUT, v);
		rd(2'h2, 1'b1);
		chk("invert", `IOX_RST_INVERT, v);
		rd(2'h3, 1'b1);
		chk("direction", `IOX_RST_DIR, v);
		$display("reset test done");
		o = 8'($urandom);
		inv = 8'($urandom);
		dir = 8'($urandom);
		wr(2'h1, o);
		wr(2'h2, inv);
		wr(2'h3, dir);
		wr(2'h0, ~o);
		rd(2'h1, 1'b1);
		chk("output", o, v);
		rd(2'h2, 1'b1);
		chk("invert", inv, v);
		rd(2'h3, 1'b1);
		chk("direction", dir, v);
		chk("oe", ~dir, pins_oe);
		chk("high side", ~dir & o, drv.high_side_driver);
		chk("low side", ~dir & ~o, drv.low_side_driver);
		chk("pins out", o, pins_out);
		$display("register test done");
		bus_addr_sel <= 1'b1;
		pins <= 8'($urandom);
		rd(2'h0, 1'b1);
		chk("input", pins ^ inv, v);
		pins <= ~pins;
		rd(2'h0, 1'b0);
		chk("input again", pins ^ inv, v);
		$display("input test done");
		wr(2'h3, 8'hff);
		rd(2'h0, 1'b1);
		pins <= pins ^ 8'h10;
		alert(1'b1);
		pins <= pins ^ 8'h10;
		alert(1'b0);
		pins <= pins ^ 8'h01;
		alert(1'b1);
		go(1'b1, `IOX_ADDR_BASE ^ 6'h01);
		m.stop();
		chk("foreign nak", 8'h01, {7'h00, a});
		chk("alert kept", 8'h01, {7'h00, alert_n_oe});
		rd(2'h0, 1'b0);
		alert(1'b0);
		pins <= pins ^ 8'h80;
		alert(1'b1);
		rd(2'h0, 1'b0);
		wr(2'h3, 8'hfe);
		pins <= pins ^ 8'h01;
		m.hold(`IOX_T_IV_CYC);
		chk("alert output pin", 8'h00, {7'h00, alert_n_oe});
		wr(2'h3, 8'hff);
		alert(1'b1);
		$display("alert test done");
		// pin held four edges: two sync flops, the reset edge, one to settle
		reset_n_pin <= 1'b0;
		m.hold(4);
		chk("oe in reset", 8'h00, pins_oe);
		reset_n_pin <= 1'b1;
		m.hold(4);
		chk("alert after reset", 8'h00, {7'h00, alert_n_oe});
		rd(2'h3, 1'b1);
		chk("direction", `IOX_RST_DIR, v);
		$display("reset pin test done");
		print_verdict();
	end
endmodule : iox_port_core_tb_top
